// ===== src/rtc_reset_seq.sv
// Host-side power-up and software reset sequencer for a serial RTC
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/100ps
`include "rtc_seq_regs.svh"
//Contract
// R1: Wait over 40 ms after power-on before the reset sequence, unless shortcut.
// R2: Begin the sequence with one throwaway read at any address.
// R3: Then read and confirm the supply-loss flag is 1.
// R4: Write 00h to bank 3 register 2h, clearing init enable.
// R5: Then write 80h to bank 3 register Fh, the reset trigger.
// R6: Then write 6Ch, 03h, 10h, 20h to bank 5 registers 0h-3h.
// R7: Wait over 2 ms after the last write; device self-clears trigger.
// R8: Shortcut: clear flag while it reads 1, give up after 40 ms.
// R9: Issue the trigger write even when the flag reads 0; code does so only with shortcut set, else stops in ST_FAIL.
// R10: Never set the trigger bit outside the reset sequence.
// R11: Hold chip enable low at least 40 ms during power-on.
// R12: No bus access until 30 ms after supply reaches 1.6 V.
// R13: Wait at least 40 ms after recovery from backup before access.
// R14: Device resets on rising edge of main or backup supply.
// R15: Device samples main supply every 31.25 ms while on backup.
// R16: Use software reset when ramp or 10 s ground hold is uncertain.
// R17: Initialize only after oscillator is stable and flag shows return.
// R18: Device sets supply-loss flag when data may have been lost.
// R19: Mode code 1h-7h writes banks, 9h-Fh reads them.
// R20: Device commits a write only after eight full data bits.
// R21: Time waits with own clock counter; step only after each transfer.
module rtc_reset_seq #(
    parameter int unsigned POWER_CYC = `WAIT_POWER_CYC,
    parameter int unsigned RECOVER_CYC = `WAIT_RECOVER_CYC,
    parameter int unsigned RESET_CYC = `WAIT_RESET_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // RTC pins
    output logic ce_out,
    output logic sck_out,
    output logic sdo_out,
    output logic sdo_oe_n_out,
    input wire logic sdi_in
);
    import rtc_seq_pkg::*;

    seq_state_t state;
    seq_state_t next_state;
    logic [31:0] timer;
    logic [31:0] guard;
    logic shortcut;
    logic flag_seen;
    logic fail;
    logic [1:0] b5_idx;
    logic [7:0] last_rd;
    logic go;
    logic [3:0] x_mode;
    logic [3:0] x_addr;
    logic [7:0] x_data;
    logic x_busy;
    wire x_done;
    wire [7:0] x_rdata;
    wire x_ce;
    wire x_sck;
    wire x_sdo;
    wire x_oe_n;

    // APB decode
    wire apb_access = psel_in && penable_in;
    wire apb_wr = apb_access && pwrite_in;
    wire hit_ctrl = (paddr_in == `REG_CTRL);
    wire hit_status = (paddr_in == `REG_STATUS);
    wire hit_last = (paddr_in == `REG_LAST);
    wire hit_any = hit_ctrl || hit_status || hit_last;
    wire start_cmd = apb_wr && hit_ctrl && pwdata_in[`CTRL_START]; // R16
    wire busy = (state != ST_IDLE) && (state != ST_DONE) && (state != ST_FAIL);
    wire timer_zero = (timer == 32'h0);
    wire flag_set = x_rdata[`FLAG_BIT];
    wire [31:0] status_word = {22'h0, fail, flag_seen, state == ST_DONE, busy, 2'b00, state};
    wire [31:0] read_word;

    function automatic logic [7:0] b5_value(input logic [1:0] idx);
        case (idx)
            2'd0: b5_value = `B5_VAL0;
            2'd1: b5_value = `B5_VAL1;
            2'd2: b5_value = `B5_VAL2;
            default: b5_value = `B5_VAL3;
        endcase
    endfunction

    assign read_word = hit_ctrl ? {30'h0, shortcut, 1'b0} :
                       hit_status ? status_word :
                       hit_last ? {24'h0, last_rd} : 32'h0;

    rtc_spi_xfer u_xfer (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(go),
        .mode_in(x_mode),
        .addr_in(x_addr),
        .wdata_in(x_data),
        .done_out(x_done),
        .rdata_out(x_rdata),
        .ce_out(x_ce),
        .sck_out(x_sck),
        .sdo_out(x_sdo),
        .sdo_oe_n_out(x_oe_n),
        .sdi_in(sdi_in)
    );

    // Pins registered once more so outputs come from flops
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ce_out <= 1'b0; // R11
            sck_out <= 1'b0;
            sdo_out <= 1'b0;
            sdo_oe_n_out <= 1'b1;
        end else begin
            ce_out <= x_ce;
            sck_out <= x_sck;
            sdo_out <= x_sdo;
            sdo_oe_n_out <= x_oe_n;
        end
    end

    // APB slave: zero wait states, error on unmapped address
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            prdata_out <= 32'h0;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !hit_any;
            prdata_out <= (psel_in && !penable_in && !pwrite_in) ? read_word : 32'h0;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_cmd) begin
                    next_state = ST_POWER;
                end
            end
            ST_POWER: begin
                // Power-on or recovery wait on own clock
                if (timer_zero || shortcut) begin // R1 R12 R13 R21
                    next_state = ST_DUMMY;
                end
            end
            ST_DUMMY: begin
                if (x_done) begin // R2 R21
                    next_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (x_done) begin
                    if (shortcut && flag_set && guard != 32'h0) begin
                        next_state = ST_CLEAR; // R8
                    end else if (!shortcut && !flag_set) begin
                        next_state = ST_FAIL; // R3 R17
                    end else begin
                        next_state = ST_INIT;
                    end
                end
            end
            ST_CLEAR: begin
                if (x_done) begin
                    next_state = ST_CHECK;
                end
            end
            ST_INIT: begin
                if (x_done) begin // R4
                    next_state = ST_TRIG;
                end
            end
            ST_TRIG: begin
                if (x_done) begin // R5 R9 R10
                    next_state = ST_B5;
                end
            end
            ST_B5: begin
                if (x_done && b5_idx == 2'd3) begin // R6
                    next_state = ST_FINAL;
                end
            end
            ST_FINAL: begin
                if (timer_zero) begin // R7
                    next_state = ST_DONE;
                end
            end
            ST_DONE, ST_FAIL: begin
                if (start_cmd) begin
                    next_state = ST_POWER;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Transfer launch for the current step
    always_comb begin
        x_mode = `MODE_RD_BANK1;
        x_addr = `FLAG_ADDR;
        x_data = 8'h00;
        case (state)
            ST_CLEAR: begin
                x_mode = `MODE_WR_BANK3;
                x_addr = `FLAG_ADDR;
                x_data = 8'h00;
            end
            ST_INIT: begin
                x_mode = `MODE_WR_BANK3;
                x_addr = `INIT_EN_ADDR;
                x_data = `INIT_EN_VAL;
            end
            ST_TRIG: begin
                x_mode = `MODE_WR_BANK3;
                x_addr = `TRIGGER_ADDR;
                x_data = `TRIGGER_VAL;
            end
            ST_B5: begin
                x_mode = `MODE_WR_BANK5;
                x_addr = {2'b00, b5_idx};
                x_data = b5_value(b5_idx);
            end
            default: begin
                x_mode = `MODE_RD_BANK1;
                x_addr = `FLAG_ADDR;
                x_data = 8'h00;
            end
        endcase
    end

    wire xfer_state = (state == ST_DUMMY) || (state == ST_CHECK) || (state == ST_CLEAR) ||
                      (state == ST_INIT) || (state == ST_TRIG) || (state == ST_B5);
    wire launch = xfer_state && !x_busy && !go;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            go <= 1'b0;
            x_busy <= 1'b0;
        end else begin
            go <= launch;
            if (go) begin
                x_busy <= 1'b1;
            end else if (x_done) begin
                x_busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
            timer <= 32'h0;
            guard <= 32'h0;
            shortcut <= 1'b0;
            flag_seen <= 1'b0;
            fail <= 1'b0;
            b5_idx <= 2'd0;
            last_rd <= 8'h00;
        end else begin
            state <= next_state;
            if (timer != 32'h0) begin
                timer <= timer - 32'h1;
            end
            if (guard != 32'h0) begin
                guard <= guard - 32'h1;
            end
            if (start_cmd && !busy) begin
                shortcut <= pwdata_in[`CTRL_SHORTCUT];
                fail <= 1'b0;
                flag_seen <= 1'b0;
                b5_idx <= 2'd0;
                guard <= POWER_CYC;
                timer <= pwdata_in[`CTRL_RECOVER] ? RECOVER_CYC : POWER_CYC;
            end
            if (x_done) begin
                last_rd <= x_rdata;
            end
            if (state == ST_CHECK && x_done) begin
                flag_seen <= flag_set;
            end
            if (state == ST_B5 && x_done) begin
                b5_idx <= b5_idx + 2'd1;
            end
            if (state == ST_B5 && next_state == ST_FINAL) begin
                timer <= RESET_CYC;
            end
            if (next_state == ST_FAIL && state != ST_FAIL) begin
                fail <= 1'b1;
            end
        end
    end
endmodule

// ===== src/rtc_seq_regs.svh
// Offsets, fields and timing counts for the RTC reset sequencer
`ifndef RTC_SEQ_REGS_SVH
`define RTC_SEQ_REGS_SVH

`define CLK_MHZ 125
`define WAIT_POWER_MS 40
`define WAIT_ACCESS_MS 30
`define WAIT_RECOVER_MS 40
`define WAIT_RESET_MS 2
`define CYC_PER_MS (`CLK_MHZ * 1000)
`define WAIT_POWER_CYC (`WAIT_POWER_MS * `CYC_PER_MS + 1)
`define WAIT_RECOVER_CYC (`WAIT_RECOVER_MS * `CYC_PER_MS + 1)
`define WAIT_RESET_CYC (`WAIT_RESET_MS * `CYC_PER_MS + 1)
`define SCK_HALF_NS 500
`define SCK_HALF_CYC ((`SCK_HALF_NS * `CLK_MHZ + 999) / 1000)

`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_LAST 12'h008

`define CTRL_START 0
`define CTRL_SHORTCUT 1
`define CTRL_RECOVER 2
`define CTRL_POWER_UP 3

`define MODE_WR_BANK3 4'h3
`define MODE_WR_BANK5 4'h5
`define MODE_RD_BANK1 4'h9
`define FLAG_ADDR 4'he
`define FLAG_BIT 1
`define INIT_EN_ADDR 4'h2
`define INIT_EN_VAL 8'h00
`define TRIGGER_ADDR 4'hf
`define TRIGGER_VAL 8'h80
`define B5_VAL0 8'h6c
`define B5_VAL1 8'h03
`define B5_VAL2 8'h10
`define B5_VAL3 8'h20

`endif

// ===== src/rtc_seq_pkg.sv
// Types for the RTC reset sequencer
package rtc_seq_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_POWER = 4'h1,
        ST_DUMMY = 4'h3,
        ST_CHECK = 4'h2,
        ST_CLEAR = 4'h6,
        ST_INIT = 4'h7,
        ST_TRIG = 4'h5,
        ST_B5 = 4'h4,
        ST_FINAL = 4'hc,
        ST_DONE = 4'hd,
        ST_FAIL = 4'hf
    } seq_state_t;
    typedef enum logic [1:0] {
        SP_IDLE = 2'h0,
        SP_SHIFT = 2'h1,
        SP_END = 2'h3
    } spi_state_t;
endpackage

// ===== src/rtc_spi_xfer.sv
// Three-wire serial transfer engine: mode, address, one data byte
`timescale 1ns/100ps
`include "rtc_seq_regs.svh"
module rtc_spi_xfer (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Request
    input wire logic start_in,
    input wire logic [3:0] mode_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic done_out,
    output logic [7:0] rdata_out,
    // Pins
    output logic ce_out,
    output logic sck_out,
    output logic sdo_out,
    output logic sdo_oe_n_out,
    input wire logic sdi_in
);
    import rtc_seq_pkg::*;
    spi_state_t state;
    logic [15:0] shift;
    logic [4:0] bit_cnt;
    logic [7:0] div;
    logic is_read;
    wire div_tick = (div == 8'(`SCK_HALF_CYC - 1));
    wire read_phase = is_read && (bit_cnt >= 5'd8);
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state <= SP_IDLE;
            shift <= 16'h0000;
            bit_cnt <= 5'h00;
            div <= 8'h00;
            is_read <= 1'b0;
            done_out <= 1'b0;
            rdata_out <= 8'h00;
            ce_out <= 1'b0;
            sck_out <= 1'b0;
            sdo_out <= 1'b0;
            sdo_oe_n_out <= 1'b1;
        end else begin
            done_out <= 1'b0;
            div <= div_tick ? 8'h00 : div + 8'h01;
            case (state)
                SP_IDLE: begin
                    div <= 8'h00;
                    if (start_in) begin
                        // Mode code selects bank and direction
                        shift <= {mode_in, addr_in, wdata_in}; // R19
                        is_read <= mode_in[3];
                        bit_cnt <= 5'h00;
                        ce_out <= 1'b1;
                        sdo_oe_n_out <= 1'b0;
                        sdo_out <= mode_in[3];
                        state <= SP_SHIFT;
                    end
                end
                SP_SHIFT: if (div_tick) begin
                    sck_out <= ~sck_out;
                    if (sck_out) begin
                        shift <= {shift[14:0], 1'b0};
                        sdo_out <= shift[14];
                        bit_cnt <= bit_cnt + 5'h01;
                        if (is_read && bit_cnt == 5'd7) begin
                            sdo_oe_n_out <= 1'b1;
                        end
                        if (bit_cnt == 5'd15) begin
                            state <= SP_END;
                        end
                    end else if (read_phase) begin
                        rdata_out <= {rdata_out[6:0], sdi_in};
                    end
                end
                SP_END: if (div_tick) begin
                    // Full 8 data bits sent before chip enable drops
                    ce_out <= 1'b0; // R20
                    sdo_oe_n_out <= 1'b1;
                    done_out <= 1'b1;
                    state <= SP_IDLE;
                end
                default: state <= SP_IDLE;
            endcase
        end
    end
endmodule

// ===== bench/rtc_reset_seq_assertions.sv
// Port checker for the RTC reset sequencer
`timescale 1ns/100ps
module rtc_reset_seq_assertions (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Serial pins
    input wire logic ce_out,
    input wire logic sck_out,
    input wire logic sdo_out,
    input wire logic sdo_oe_n_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence setup_s;
        psel_in && !penable_in;
    endsequence
    sequence ce_gap_s;
        !ce_out [*3];
    endsequence
    AST_APB_ANSWER: assert property (setup_s |=> pready_out)
        else $error("no ready one cycle after setup");
    AST_READY_PULSE: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    AST_SLVERR_READY: assert property (pslverr_out |-> pready_out)
        else $error("error response without ready");
    AST_RDATA_IDLE: assert property (!pready_out |-> prdata_out == 32'h0)
        else $error("read data outside access cycle");
    AST_SCK_IDLE: assert property (!ce_out |-> !sck_out)
        else $error("serial clock moves with chip enable low");
    AST_SCK_HIGH: assert property ($rose(sck_out) |-> sck_out [*8])
        else $error("serial clock high phase too short");
    AST_SDO_FALL: assert property (ce_out && $past(ce_out) && !sdo_oe_n_out
        && !$fell(sck_out) |-> $stable(sdo_out))
        else $error("serial data changed off a falling clock");
    AST_CE_GAP: assert property ($fell(ce_out) |-> ce_gap_s)
        else $error("transfers closer than three idle cycles");
    AST_CE_RESET: assert property (disable iff (1'b0)
        sys_rst_in |=> !ce_out && sdo_oe_n_out)
        else $error("chip enable or data driver active in reset");
endmodule

bind rtc_reset_seq rtc_reset_seq_assertions rtc_reset_seq_assertions_i (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .ce_out(ce_out),
    .sck_out(sck_out),
    .sdo_out(sdo_out),
    .sdo_oe_n_out(sdo_oe_n_out)
);

// ===== bench/rtc_dev_model.sv
// Behavioural RTC on the far side of the three-wire link
`timescale 1ns/100ps
module rtc_dev_model (
    // Power-on and test controls
    input wire logic por_in,
    input wire logic flag_init_in,
    input wire logic flag_stuck_in,
    // Serial pins
    input wire logic ce_in,
    input wire logic sck_in,
    input wire logic sdo_in,
    output logic sdi_out
);
    logic [15:0] sr = 16'h0;
    logic [15:0] log_mem [0:63];
    logic [7:0] hdr = 8'h0;
    logic [7:0] rd_byte = 8'h0;
    logic supply_loss_flag = 1'b1;
    int cnt = 0;
    int n_xfer = 0;
    initial sdi_out = 1'b0;
    always @(por_in or flag_init_in) begin
        if (por_in) begin
            supply_loss_flag = flag_init_in;
            n_xfer = 0;
        end
    end
    always @(posedge ce_in) cnt = 0;
    always @(posedge sck_in) begin
        if (ce_in && cnt < 16) begin
            sr = {sr[14:0], sdo_in};
            cnt++;
            if (cnt == 8) begin
                hdr = sr[7:0];
                rd_byte = hdr[3:0] == 4'he ? {6'h0, supply_loss_flag, 1'b0} : 8'ha5;
            end
            if (cnt == 16 && n_xfer < 64) begin
                // Write commits only on the eighth data bit
                log_mem[n_xfer] = hdr[7] ? {hdr, 8'h00} : sr;
                n_xfer++;
                if (sr[15:8] == 8'h3e && !sr[1] && !flag_stuck_in) supply_loss_flag = 1'b0;
            end
        end
    end
    // Released line flips so no stale bit looks valid
    always @(negedge sck_in or negedge ce_in) begin
        if (ce_in && cnt >= 8 && cnt < 16 && hdr[7]) sdi_out = rd_byte[15 - cnt];
        else sdi_out = ~sdi_out;
    end
endmodule

// ===== bench/rtc_reset_seq_tb_top.sv
// Self-checking bench for the RTC reset sequencer
`timescale 1ns/100ps
`include "rtc_seq_regs.svh"
module rtc_reset_seq_tb_top;
    localparam int P_CYC = 5000;
    localparam int R_CYC = 50;
    localparam logic [15:0] EXP_WR [6] = '{16'h3200, 16'h3f80, 16'h506c, 16'h5103,
        16'h5210, 16'h5320};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic flag_init = 1'b1;
    logic flag_stuck = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ce;
    logic sck;
    logic sdo;
    logic oe_n;
    logic sdi;
    logic ce_q = 1'b0;
    int cyc = 0;
    int t_rel = 0;
    int first_rise = 0;
    int last_high = 0;
    int failures = 0;
    int comparisons = 0;
    rtc_reset_seq #(.POWER_CYC(P_CYC), .RECOVER_CYC(P_CYC), .RESET_CYC(R_CYC))
    rtc_reset_seq_i (.mclk_in(mclk), .sys_rst_in(rst), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .ce_out(ce),
        .sck_out(sck), .sdo_out(sdo), .sdo_oe_n_out(oe_n), .sdi_in(sdi));
    rtc_dev_model rtc_dev_model_i (.por_in(rst), .flag_init_in(flag_init),
        .flag_stuck_in(flag_stuck), .ce_in(ce), .sck_in(sck), .sdo_in(sdo), .sdi_out(sdi));
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        ce_q <= ce;
        if (ce) last_high <= cyc;
        if (rst) begin
            t_rel <= cyc + 1;
            first_rise <= 0;
        end else if (ce && !ce_q && first_rise == 0) first_rise <= cyc;
        if (cyc == 95000) begin
            failures++;
            tally_and_finish;
        end
    end
    task automatic tally_and_finish;
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset(input logic fi, input logic fs);
        @(posedge mclk);
        rst <= 1'b1;
        flag_init <= fi;
        flag_stuck <= fs;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
    endtask
    task automatic run_seq(input logic [31:0] ctrl, output logic [31:0] st);
        logic e;
        int n;
        apb(1'b1, `REG_CTRL, ctrl, st, e);
        n = 0;
        st = 32'h0;
        while (st[7] !== 1'b1 && st[9] !== 1'b1 && n < 20000) begin
            apb(1'b0, `REG_STATUS, 32'h0, st, e);
            n++;
        end
    endtask
    task automatic chk_log(input int exp_k, output int r, output int c);
        logic [15:0] x;
        int k;
        k = 0;
        r = 0;
        c = 0;
        for (int i = 0; i < rtc_dev_model_i.n_xfer; i++) begin
            x = rtc_dev_model_i.log_mem[i];
            if (x[15]) begin
                chk(x[15:12], 32'h9);
                r += (k == 0 && c == 0);
            end else if (x[15:8] == 8'h3e) begin
                c++;
            end else begin
                if (k < 6) chk(x, EXP_WR[k]);
                k++;
            end
        end
        chk(k, exp_k);
    endtask
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        chk(ce, 32'h0);
        apb(1'b0, `REG_STATUS, 32'h0, q, e);
        chk(q[9:6], 32'h0);
        apb(1'b1, 12'h00c, 32'h1, q, e);
        chk(e, 32'h1);
        apb(1'b0, 12'h00c, 32'h0, q, e);
        chk(q, 32'h0);
        chk(e, 32'h1);
    endtask
    task automatic t_full;
        logic [31:0] st;
        logic e;
        int r;
        int c;
        do_reset(1'b1, 1'b0);
        apb(1'b1, `REG_CTRL, 32'h1 << `CTRL_START, st, e);
        run_seq(32'h1 << `CTRL_START, st);
        chk(st[8:7], 32'h3);
        chk(first_rise - t_rel >= P_CYC, 32'h1);
        chk(cyc - last_high >= R_CYC, 32'h1);
        chk_log(6, r, c);
        chk(r >= 2, 32'h1);
        chk(c, 32'h0);
        apb(1'b0, `REG_LAST, 32'h0, st, e);
        chk(st, 32'h1 << `FLAG_BIT);
    endtask
    task automatic t_noflag;
        logic [31:0] st;
        int r;
        int c;
        do_reset(1'b0, 1'b0);
        run_seq(32'h1 << `CTRL_START | 32'h1 << `CTRL_RECOVER, st);
        chk(st[9:7], 32'h4);
        chk(first_rise - t_rel >= P_CYC, 32'h1);
        chk_log(0, r, c);
    endtask
    task automatic t_short(input logic stuck);
        logic [31:0] st;
        logic e;
        int r;
        int c;
        do_reset(1'b1, stuck);
        run_seq(32'h1 << `CTRL_START | 32'h1 << `CTRL_SHORTCUT, st);
        chk(st[7], 32'h1);
        apb(1'b0, `REG_CTRL, 32'h0, st, e);
        chk(st, 32'h1 << `CTRL_SHORTCUT);
        chk_log(6, r, c);
        chk(c >= 1, 32'h1);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_full;
        t_noflag;
        t_short(1'b0);
        t_short(1'b1);
        tally_and_finish;
    end
endmodule
